// File: design/grt_pkg.sv
`default_nettype none
package grt_pkg;

  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int STAT_W = 2;
  localparam int PS_W   = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_COUNT  = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_OSC    = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_STAT   = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 4'h5;

  // timer_control field positions
  localparam int CTRL_ON_BIT   = 15;
  localparam int CTRL_SIDL_BIT = 13;
  localparam int CTRL_GATE_BIT = 6;
  localparam int CTRL_PS_LSB   = 4;
  localparam int CTRL_SYNC_BIT = 2;
  localparam int CTRL_CS_BIT   = 1;

  // oscillator_control field position
  localparam int OSC_LPEN_BIT = 1;

  // status and mask bit positions
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_WAKE_BIT  = 1;

  // prescale select codes
  typedef enum logic [1:0] {
    GRT_PS_1   = 2'h0,
    GRT_PS_8   = 2'h1,
    GRT_PS_64  = 2'h2,
    GRT_PS_256 = 2'h3
  } grt_ps_t;

  // prescaler terminal counts (ratio minus one)
  localparam logic [PS_W-1:0] PS_LIM_1   = 8'h00;
  localparam logic [PS_W-1:0] PS_LIM_8   = 8'h07;
  localparam logic [PS_W-1:0] PS_LIM_64  = 8'h3f;
  localparam logic [PS_W-1:0] PS_LIM_256 = 8'hff;

  // reset values
  localparam logic [DATA_W-1:0] COUNT_RST  = 16'h0000;
  localparam logic [DATA_W-1:0] PERIOD_RST = 16'hffff;
  localparam logic [STAT_W-1:0] STAT_RST   = 2'h0;

endpackage
`default_nettype wire

// File: design/grt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module grt_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  import grt_pkg::*;

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  if (WIDTH < 1) begin : g_chk
    $error("grt_sync: WIDTH must be at least 1");
  end

  // two flops, only the second is read outside
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= din;
      stage2_reg <= stage1_reg;
    end
  end

  assign dout = stage2_reg;

endmodule
`default_nettype wire

// File: design/grt_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module grt_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             clear,
  input  wire logic             tickIn,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  tickOut
);
  import grt_pkg::*;

  logic [WIDTH-1:0] div_reg;

  if (WIDTH < PS_W) begin : g_chk
    $error("grt_prescaler: WIDTH too small for divide by 256");
  end

  // counts input ticks, wraps at limit
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      div_reg <= '0;
    end else if (clear) begin
      div_reg <= '0;
    end else if (tickIn) begin
      div_reg <= (div_reg == limit) ? '0 : WIDTH'(div_reg + 1'b1);
    end
  end

  assign tickOut = tickIn && !clear && (div_reg == limit);

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_PS_CLEAR: assert property (clear |=> div_reg == '0)
    else $error("prescaler not cleared");
  AST_PS_RATIO: assert property (
    tickOut |-> (div_reg == limit) && tickIn)
    else $error("prescaler tick off its ratio");
  AST_PS_STEP: assert property (
    (tickIn && !clear && div_reg != limit)
    |=> div_reg == WIDTH'($past(div_reg) + 1'b1))
    else $error("prescaler did not advance by one");

endmodule
`default_nettype wire

// File: design/grt_timer16.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - gated mode counts instruction cycles only while the gate pin is high
// - in idle the count halts when idle stop is set, else it runs
// - input ticks pass a prescaler of 1, 8, 64 or 256
// - count write or control write while the timer is on, and reset, clear the prescaler
// - with the timer off only reset clears the prescaler
// - control writes keep the count; only count writes change it
// - in sleep only an on, external, unsynchronised timer counts
// - count rises to the period value, then wraps to zero
// - period match sets the match flag, interrupt if enabled
// - match flag stays set until software writes one to clear it
// - gate falling edge in gated mode also sets the match flag
// - on, external, ungated timer counts oscillator rising edges when the oscillator is enabled, else gate pin rising edges
// - oscillator enable blocks normal modes, wakes on carry-out
// - unsynchronised oscillator counting continues through sleep
// - interrupt output follows flag and its enable both being set, one cycle later
module grt_timer16 (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic [grt_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [grt_pkg::DATA_W-1:0] wrData,
  input  wire logic                       wrStrobe,
  input  wire logic                       rdStrobe,
  output logic      [grt_pkg::DATA_W-1:0] rdData,
  input  wire logic                       gateClockInput,
  input  wire logic                       lowPowerOscClk,
  input  wire logic                       cpuIdle,
  input  wire logic                       cpuSleep,
  output logic                            irqOut,
  output logic                            wakeEvent
);
  import grt_pkg::*;

  logic                wrCtrl;
  logic                wrCount;
  logic                wrPeriod;
  logic                wrOsc;
  logic                wrStat;
  logic                wrMask;

  logic                timerOn_reg;
  logic                idleStop_reg;
  logic                gateAccumulateEnable_reg;
  grt_ps_t             prescaleSelect_reg;
  logic                extClockSync_reg;
  logic                clockSourceSelect_reg;
  logic                lowPowerOscEnable_reg;
  logic [DATA_W-1:0]   period_reg;
  logic [DATA_W-1:0]   countValue_reg;
  logic [DATA_W-1:0]   countValue_next;
  logic [STAT_W-1:0]   irqFlag_reg;
  logic [STAT_W-1:0]   irqFlag_next;
  logic [STAT_W-1:0]   irqEnable_reg;
  logic [STAT_W-1:0]   flagSet;
  logic [STAT_W-1:0]   flagClr;
  logic                irqOut_reg;
  logic                wakeEvent_reg;
  logic [DATA_W-1:0]   rdData_reg;
  logic [DATA_W-1:0]   ctrlView;
  logic [DATA_W-1:0]   oscView;

  logic [1:0]          pinSync;
  logic [1:0]          pinPrev_reg;
  logic                gateLevel;
  logic                gateFall;
  logic                extRise;
  logic                srcTick;
  logic                runOk;
  logic                tickIn;
  logic                psClear;
  logic [PS_W-1:0]     psLimit;
  logic                incr;
  logic                match;
  logic                rollover;
  logic                gateEnd;

  // register decode
  assign wrCtrl   = wrStrobe && (regAddr == ADDR_CTRL);
  assign wrCount  = wrStrobe && (regAddr == ADDR_COUNT);
  assign wrPeriod = wrStrobe && (regAddr == ADDR_PERIOD);
  assign wrOsc    = wrStrobe && (regAddr == ADDR_OSC);
  assign wrStat   = wrStrobe && (regAddr == ADDR_STAT);
  assign wrMask   = wrStrobe && (regAddr == ADDR_MASK);

  // timer control fields; writing them leaves the count alone
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      timerOn_reg              <= 1'b0;
      idleStop_reg             <= 1'b0;
      gateAccumulateEnable_reg <= 1'b0;
      prescaleSelect_reg       <= GRT_PS_1;
      extClockSync_reg         <= 1'b0;
      clockSourceSelect_reg    <= 1'b0;
    end else if (wrCtrl) begin
      timerOn_reg              <= wrData[CTRL_ON_BIT];
      idleStop_reg             <= wrData[CTRL_SIDL_BIT];
      gateAccumulateEnable_reg <= wrData[CTRL_GATE_BIT];
      prescaleSelect_reg       <= grt_ps_t'(wrData[CTRL_PS_LSB +: 2]);
      extClockSync_reg         <= wrData[CTRL_SYNC_BIT];
      clockSourceSelect_reg    <= wrData[CTRL_CS_BIT];
    end
  end

  // oscillator control
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      lowPowerOscEnable_reg <= 1'b0;
    end else if (wrOsc) begin
      lowPowerOscEnable_reg <= wrData[OSC_LPEN_BIT];
    end
  end

  // period register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      period_reg <= PERIOD_RST;
    end else if (wrPeriod) begin
      period_reg <= wrData;
    end
  end

  // pins cross into ref_clk through two flops
  grt_sync #(
    .WIDTH (2)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .din     ({lowPowerOscClk, gateClockInput}),
    .dout    (pinSync)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pinPrev_reg <= 2'h0;
    end else begin
      pinPrev_reg <= pinSync;
    end
  end

  assign gateLevel = pinSync[0];
  assign gateFall  = !pinSync[0] && pinPrev_reg[0];
  // external source: oscillator when enabled, else the gate pin
  assign extRise   = lowPowerOscEnable_reg ?
                     (pinSync[1] && !pinPrev_reg[1]) :
                     (pinSync[0] && !pinPrev_reg[0]);

  // source tick selection
  always_comb begin
    srcTick = 1'b0;
    if (clockSourceSelect_reg) begin
      srcTick = extRise && !(lowPowerOscEnable_reg &&
                             gateAccumulateEnable_reg);
    end else if (lowPowerOscEnable_reg) begin
      srcTick = 1'b0;
    end else if (gateAccumulateEnable_reg) begin
      srcTick = gateLevel;
    end else begin
      srcTick = 1'b1;
    end
  end

  // power-state gating
  always_comb begin
    runOk = timerOn_reg;
    if (cpuIdle && idleStop_reg) begin
      runOk = 1'b0;
    end
    if (cpuSleep && !(clockSourceSelect_reg && !extClockSync_reg)) begin
      runOk = 1'b0;
    end
  end

  assign tickIn  = runOk && srcTick;
  assign psClear = (wrCount || wrCtrl) && timerOn_reg;

  always_comb begin
    case (prescaleSelect_reg)
      GRT_PS_1:   psLimit = PS_LIM_1;
      GRT_PS_8:   psLimit = PS_LIM_8;
      GRT_PS_64:  psLimit = PS_LIM_64;
      GRT_PS_256: psLimit = PS_LIM_256;
      default:    psLimit = PS_LIM_1;
    endcase
  end

  grt_prescaler #(
    .WIDTH (PS_W)
  ) u_prescaler (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .clear   (psClear),
    .tickIn  (tickIn),
    .limit   (psLimit),
    .tickOut (incr)
  );

  assign match    = (countValue_reg == period_reg);
  assign rollover = incr && match;
  assign gateEnd  = timerOn_reg && !clockSourceSelect_reg &&
                    gateAccumulateEnable_reg && !lowPowerOscEnable_reg &&
                    gateFall;

  // count value
  always_comb begin
    countValue_next = countValue_reg;
    if (wrCount) begin
      countValue_next = wrData;
    end else if (rollover) begin
      countValue_next = COUNT_RST;
    end else if (incr) begin
      countValue_next = DATA_W'(countValue_reg + 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      countValue_reg <= COUNT_RST;
    end else begin
      countValue_reg <= countValue_next;
    end
  end

  // sticky flags, write one to clear, set wins
  always_comb begin
    flagSet                 = '0;
    flagSet[STAT_MATCH_BIT] = rollover || gateEnd;
    flagSet[STAT_WAKE_BIT]  = rollover && lowPowerOscEnable_reg;
    flagClr                 = wrStat ? wrData[STAT_W-1:0] : '0;
    irqFlag_next            = (irqFlag_reg & ~flagClr) | flagSet;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irqFlag_reg <= STAT_RST;
    end else begin
      irqFlag_reg <= irqFlag_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irqEnable_reg <= STAT_RST;
    end else if (wrMask) begin
      irqEnable_reg <= wrData[STAT_W-1:0];
    end
  end

  // interrupt and wake outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irqOut_reg <= 1'b0;
    end else begin
      irqOut_reg <= |(irqFlag_reg & irqEnable_reg);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wakeEvent_reg <= 1'b0;
    end else begin
      wakeEvent_reg <= rollover && lowPowerOscEnable_reg;
    end
  end

  // read views
  always_comb begin
    ctrlView                        = '0;
    ctrlView[CTRL_ON_BIT]           = timerOn_reg;
    ctrlView[CTRL_SIDL_BIT]         = idleStop_reg;
    ctrlView[CTRL_GATE_BIT]         = gateAccumulateEnable_reg;
    ctrlView[CTRL_PS_LSB +: 2]      = prescaleSelect_reg;
    ctrlView[CTRL_SYNC_BIT]         = extClockSync_reg;
    ctrlView[CTRL_CS_BIT]           = clockSourceSelect_reg;
    oscView                         = '0;
    oscView[OSC_LPEN_BIT]           = lowPowerOscEnable_reg;
  end

  // read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rdData_reg <= '0;
    end else if (rdStrobe) begin
      case (regAddr)
        ADDR_CTRL:   rdData_reg <= ctrlView;
        ADDR_COUNT:  rdData_reg <= countValue_reg;
        ADDR_PERIOD: rdData_reg <= period_reg;
        ADDR_OSC:    rdData_reg <= oscView;
        ADDR_STAT:   rdData_reg <= {{(DATA_W-STAT_W){1'b0}}, irqFlag_reg};
        ADDR_MASK:   rdData_reg <= {{(DATA_W-STAT_W){1'b0}}, irqEnable_reg};
        default:     rdData_reg <= '0;
      endcase
    end else begin
      rdData_reg <= '0;
    end
  end

  assign rdData    = rdData_reg;
  assign irqOut    = irqOut_reg;
  assign wakeEvent = wakeEvent_reg;

  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_GATE_LOW_HOLDS: assert property (
    (timerOn_reg && !clockSourceSelect_reg && gateAccumulateEnable_reg &&
     !gateLevel && !wrCount)
    |=> $stable(countValue_reg))
    else $error("count moved while gate low");

  AST_IDLE_STOP: assert property (
    (cpuIdle && idleStop_reg && !wrCount) |=> $stable(countValue_reg))
    else $error("count moved in idle with stop set");

  AST_SLEEP_STOP: assert property (
    (cpuSleep && !(clockSourceSelect_reg && !extClockSync_reg) &&
     !wrCount) |=> $stable(countValue_reg))
    else $error("count moved in sleep without async source");

  AST_OFF_NO_PS_CLEAR: assert property (
    !timerOn_reg |-> !psClear)
    else $error("prescaler cleared while off");

  AST_CTRL_KEEPS_COUNT: assert property (
    (wrCtrl && !incr) |=> countValue_reg == $past(countValue_reg))
    else $error("control write changed the count");

  AST_WRAP_ZERO: assert property (
    (rollover && !wrCount) |=> countValue_reg == COUNT_RST)
    else $error("count did not wrap to zero");
  AST_STEP_ONE: assert property (
    (incr && !match && !wrCount)
    |=> countValue_reg == DATA_W'($past(countValue_reg) + 1'b1))
    else $error("count did not step by one");
  AST_MATCH_FLAG: assert property (
    rollover |=> irqFlag_reg[STAT_MATCH_BIT])
    else $error("match did not set flag");

  AST_FLAG_STICKY: assert property (
    (irqFlag_reg[STAT_MATCH_BIT] && !(wrStat && wrData[STAT_MATCH_BIT]))
    |=> irqFlag_reg[STAT_MATCH_BIT])
    else $error("flag dropped without a clear");

  AST_GATE_END_FLAG: assert property (
    gateEnd |=> irqFlag_reg[STAT_MATCH_BIT])
    else $error("gate fall did not set flag");

  AST_IRQ_FOLLOWS: assert property (
    (irqFlag_reg & irqEnable_reg) != '0 |=> irqOut)
    else $error("enabled flag gave no interrupt");
  AST_IRQ_MASKED: assert property (
    (irqFlag_reg & irqEnable_reg) == '0 |=> !irqOut)
    else $error("interrupt without enabled flag");

  AST_WAKE_PULSE: assert property (
    (rollover && lowPowerOscEnable_reg)
    |=> wakeEvent && irqFlag_reg[STAT_WAKE_BIT])
    else $error("carry-out gave no wake event");
  AST_LP_NO_INTERNAL: assert property (
    (lowPowerOscEnable_reg && !clockSourceSelect_reg) |-> !tickIn)
    else $error("internal counting with oscillator enabled");
endmodule
`default_nettype wire

// File: testbench/grt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module grt_pin_model (
  input  wire logic ref_clk,
  output var logic  gateClockInput,
  output var logic  lowPowerOscClk
);
  // both pins rest low between bursts, so no stale edge reaches the timer
  initial begin
    gateClockInput = 1'b0;
    lowPowerOscClk = 1'b0;
  end

  // n rising edges; high for hi cycles, low for four, never under two
  task automatic pulses(input bit osc, input int n, input int hi);
    repeat (n) begin
      @(posedge ref_clk);
      if (osc) lowPowerOscClk <= 1'b1;
      else gateClockInput <= 1'b1;
      repeat (hi) @(posedge ref_clk);
      if (osc) lowPowerOscClk <= 1'b0;
      else gateClockInput <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/gated_rtc_timer16_tb.sv
`timescale 1ns/1ps
`default_nettype none
module gated_rtc_timer16_tb;
  import grt_pkg::*;
  logic              ref_clk;
  logic              rst_b;
  logic              wrStrobe;
  logic              rdStrobe;
  logic              rdSeen;
  logic              cpuIdle;
  logic              cpuSleep;
  logic              gateClockInput;
  logic              lowPowerOscClk;
  logic              irqOut;
  logic              wakeEvent;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W-1:0] rdData;
  logic [DATA_W-1:0] expQ[$];
  logic [3:0]        idx[7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hf};
  int                mismatches = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                wakeCnt = 0;
  int                n;
  int                k;

  grt_timer16 u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .gateClockInput(gateClockInput), .lowPowerOscClk(lowPowerOscClk),
    .cpuIdle(cpuIdle), .cpuSleep(cpuSleep), .irqOut(irqOut),
    .wakeEvent(wakeEvent)
  );

  grt_pin_model u_pins (
    .ref_clk(ref_clk), .gateClockInput(gateClockInput),
    .lowPowerOscClk(lowPowerOscClk)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rdSeen) check("rdData", rdData, expQ.pop_front());
    rdSeen <= rdStrobe;
    if (wakeEvent === 1'b1) wakeCnt++;
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      final_report();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge ref_clk);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regAddr <= a;
    rdStrobe <= 1'b1;
    expQ.push_back(exp);
    @(posedge ref_clk);
    rdStrobe <= 1'b0;
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge ref_clk);
  endtask

  task automatic ext(input int c);
    u_pins.pulses(1'b0, c, 2);
    idle(6);
  endtask

  initial begin
    rst_b = 1'b0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    rdSeen = 1'b0;
    regAddr = '0;
    wrData = '0;
    cpuIdle = 1'b0;
    cpuSleep = 1'b0;
    void'($urandom(53884));
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 7; i++) rd(idx[i], (i == 2) ? 16'hffff : 16'h0000);
    // external pin at 1:1 wraps after the period value
    wr(ADDR_PERIOD, 16'h0003);
    wr(ADDR_CTRL, 16'h8002);
    ext(5);
    rd(ADDR_COUNT, 16'h0001);
    rd(ADDR_STAT, 16'h0001);
    idle(3);
    check("irqOut", {15'h0, irqOut}, 16'h0000);
    wr(ADDR_MASK, 16'h0001);
    idle(2);
    check("irqOut", {15'h0, irqOut}, 16'h0001);
    rd(ADDR_STAT, 16'h0001);
    wr(ADDR_STAT, 16'h0001);
    idle(2);
    check("irqOut", {15'h0, irqOut}, 16'h0000);
    rd(ADDR_STAT, 16'h0000);
    // every prescale ratio: one edge short, then the carrying edge
    wr(ADDR_PERIOD, 16'hffff);
    for (int p = 0; p < 4; p++) begin
      n = (p == 3) ? 256 : (1 << (3 * p));
      wr(ADDR_CTRL, 16'h8002 | 16'(p << 4));
      wr(ADDR_COUNT, 16'h0000);
      ext(n - 1);
      rd(ADDR_COUNT, 16'h0000);
      ext(1);
      rd(ADDR_COUNT, 16'h0001);
    end
    wr(ADDR_CTRL, 16'h8012);
    rd(ADDR_COUNT, 16'h0001);
    ext(4);
    wr(ADDR_CTRL, 16'h8012);
    ext(4);
    rd(ADDR_COUNT, 16'h0001);
    // idle with and without idle stop
    cpuIdle <= 1'b1;
    wr(ADDR_CTRL, 16'ha002);
    wr(ADDR_COUNT, 16'h0000);
    ext(3);
    rd(ADDR_COUNT, 16'h0000);
    cpuIdle <= 1'b0;
    ext(2);
    rd(ADDR_COUNT, 16'h0002);
    cpuIdle <= 1'b1;
    wr(ADDR_CTRL, 16'h8002);
    ext(3);
    rd(ADDR_COUNT, 16'h0005);
    cpuIdle <= 1'b0;
    // sleep: internal and synchronised sources stop, asynchronous runs
    cpuSleep <= 1'b1;
    wr(ADDR_CTRL, 16'h8000);
    wr(ADDR_COUNT, 16'h0000);
    idle(10);
    rd(ADDR_COUNT, 16'h0000);
    n = $urandom_range(9, 2);
    wr(ADDR_CTRL, 16'h8006);
    ext(n);
    rd(ADDR_COUNT, 16'h0000);
    wr(ADDR_CTRL, 16'h8002);
    ext(n);
    rd(ADDR_COUNT, 16'(n));
    cpuSleep <= 1'b0;
    // gated accumulation over a random gate width
    wr(ADDR_STAT, 16'h0003);
    wr(ADDR_CTRL, 16'h8040);
    wr(ADDR_COUNT, 16'h0000);
    k = n + 4;
    u_pins.pulses(1'b0, 1, k);
    idle(6);
    rd(ADDR_COUNT, 16'(k));
    rd(ADDR_STAT, 16'h0001);
    check("irqOut", {15'h0, irqOut}, 16'h0001);
    // oscillator mode through sleep, gate pin must be ignored
    wr(ADDR_STAT, 16'h0003);
    wr(ADDR_PERIOD, 16'h0002);
    wr(ADDR_MASK, 16'h0003);
    wr(ADDR_OSC, 16'h0002);
    wr(ADDR_CTRL, 16'h8002);
    wr(ADDR_COUNT, 16'h0000);
    cpuSleep <= 1'b1;
    wakeCnt = 0;
    fork
      u_pins.pulses(1'b1, 7, 2);
      u_pins.pulses(1'b0, 5, 2);
    join
    idle(6);
    rd(ADDR_COUNT, 16'h0001);
    rd(ADDR_STAT, 16'h0003);
    check("wakeCnt", 16'(wakeCnt), 16'h0002);
    cpuSleep <= 1'b0;
    wr(ADDR_CTRL, 16'h8000);
    wr(ADDR_COUNT, 16'h0000);
    idle(10);
    rd(ADDR_COUNT, 16'h0000);
    idle(3);
    final_report();
  end
endmodule
`default_nettype wire
